// [src/gle_regs.vh]
`ifndef GLE_REGS_VH
`define GLE_REGS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------
`define GLE_OFF_FSEL0   8'h00
`define GLE_OFF_FSEL5   8'h14
`define GLE_OFF_RAISE0  8'h20
`define GLE_OFF_RAISE1  8'h24
`define GLE_OFF_LOWER0  8'h28
`define GLE_OFF_LOWER1  8'h2c
`define GLE_OFF_STATE0  8'h30
`define GLE_OFF_STATE1  8'h34
`define GLE_OFF_STAT0   8'h40
`define GLE_OFF_STAT1   8'h44
`define GLE_OFF_RISE0   8'h48
`define GLE_OFF_RISE1   8'h4c
`define GLE_OFF_FALL0   8'h50
`define GLE_OFF_FALL1   8'h54
`define GLE_OFF_HIGH0   8'h58
`define GLE_OFF_HIGH1   8'h5c
`define GLE_OFF_MASK0   8'h60
`define GLE_OFF_MASK1   8'h64

// ----------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------
`define GLE_BANK0_PINS  32
`define GLE_BANK1_PINS  22
`define GLE_FSEL_BITS   3
`define GLE_FSEL_PER_REG 10
`define GLE_FSEL_INPUT  3'h0
`define GLE_FSEL_OUTPUT 3'h1

// ----------------------------------------------------------------
// Reset values and sampling patterns
// ----------------------------------------------------------------
`define GLE_RST_WORD    32'h0000_0000
`define GLE_RST_FSEL    30'h0000_0000
`define GLE_PAT_RISE    3'h3
`define GLE_PAT_FALL    3'h4

`endif

// [src/gle_event_det.v]
`timescale 1ns/10ps
`include "gle_regs.vh"

module gle_event_det #(
   parameter WIDTH = 32
) (
   input wire sys_clk_i,
   input wire rst_n_i,
   input wire [WIDTH-1:0] pin_i,
   input wire [WIDTH-1:0] rise_en_i,
   input wire [WIDTH-1:0] fall_en_i,
   input wire [WIDTH-1:0] high_en_i,
   input wire [WIDTH-1:0] clear_i,
   output wire [WIDTH-1:0] status_o
);

   genvar g;

   // ----------------------------------------------------------------
   // Per-pin sampling history and sticky status
   // ----------------------------------------------------------------
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_pin
         reg [2:0] hist;
         reg status;
         wire rise_hit;
         wire fall_hit;
         wire high_hit;
         wire event_hit;

         // Oldest sample in bit 2, newest in bit 0
         always @(posedge sys_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               hist <= 3'h0;
            end else begin
               hist <= {hist[1:0], pin_i[g]};
            end
         end

         // Pattern match ignores a one-cycle pulse's leading edge, but not its trailing edge
         assign rise_hit = rise_en_i[g] && (hist == `GLE_PAT_RISE);
         assign fall_hit = fall_en_i[g] && (hist == `GLE_PAT_FALL);
         assign high_hit = high_en_i[g] && hist[0];
         assign event_hit = rise_hit | fall_hit | high_hit;

         // Set beats clear; a held high level re-sets every cycle
         always @(posedge sys_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               status <= 1'b0;
            end else if (event_hit) begin
               status <= 1'b1;
            end else if (clear_i[g]) begin
               status <= 1'b0;
            end
         end

         assign status_o[g] = status;
      end
   endgenerate

endmodule // gle_event_det

// [src/gle_fsel.v]
`timescale 1ns/10ps
`include "gle_regs.vh"

module gle_fsel #(
   parameter PINS = 54
) (
   input wire sys_clk_i,
   input wire rst_n_i,
   input wire [7:0] addr_i,
   input wire wr_i,
   input wire [31:0] wdata_i,
   output wire hit_o,
   output reg [31:0] rdata_o,
   output wire [3*PINS-1:0] pin_func_o
);

   localparam REGS = (PINS + 9) / 10;

   wire [2:0] idx;
   reg [29:0] sel_word [0:REGS-1];
   genvar k;
   genvar p;

   // ----------------------------------------------------------------
   // Decode of the function select block
   // ----------------------------------------------------------------
   assign idx = addr_i[4:2];
   assign hit_o = (addr_i[7:5] == 3'h0) && (addr_i[1:0] == 2'h0) &&
                  ({29'h0, idx} < REGS);

   // Select words; absent fields of the last word stay zero
   generate
      for (k = 0; k < REGS; k = k + 1) begin : g_word
         localparam NF = (PINS - 10 * k > 10) ? 10 : PINS - 10 * k;
         localparam [29:0] FMASK = 30'h3fffffff >> (30 - 3 * NF);
         always @(posedge sys_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               sel_word[k] <= `GLE_RST_FSEL;
            end else if (wr_i && hit_o && idx == k) begin
               sel_word[k] <= wdata_i[29:0] & FMASK;
            end
         end
      end
   endgenerate

   // Per-pin code fan-out
   generate
      for (p = 0; p < PINS; p = p + 1) begin : g_code
         assign pin_func_o[3*p+2:3*p] = sel_word[p/10][3*(p%10)+2:3*(p%10)];
      end
   endgenerate

   // Read-back of the addressed word
   always @* begin
      rdata_o = `GLE_RST_WORD;
      if (hit_o) begin
         rdata_o = {2'h0, sel_word[idx]};
      end
   end

endmodule // gle_fsel

// [src/gle_top.v]
//
// Contract
// - Raise-register ones set the output latch of matching pins; zeros do nothing.
// - Lower-register ones clear the output latch of matching pins; zeros do nothing.
// - Pins configured as inputs are not driven by raise or lower writes.
// - Latch updates always; switching to output drives the latest latch value.
// - Pin state registers return present pin levels; bank one in bits 21-0.
// - An enabled rising or falling edge sets the pin's event status bit.
// - An enabled level on a pin sets the pin's event status bit.
// - Writing one clears a status bit; zero leaves it; reads show events.
// - Each bank drives an interrupt line while any of its status bits set.
// - A third interrupt line is high while any status bit is set.
// - Rising edge seen only on sampled history pattern 011.
// - Falling edge seen only on sampled history pattern 100.
// - Both edge enables set make every transition held for two samples set the status bit.
// - High-level enable set makes a high pin set status; zero disables it.
// - Status stays set if high-level enable is set and the pin is still high when cleared.
// - Function code 000 is input, 001 output; all codes reset to input.
//
`timescale 1ns/10ps
`include "gle_regs.vh"

module gle_top #(
   parameter BANK0_PINS = `GLE_BANK0_PINS,
   parameter BANK1_PINS = `GLE_BANK1_PINS
) (
   input wire sys_clk_i,
   input wire rst_n_i,
   input wire [7:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output wire [31:0] rdata_o,
   input wire [BANK0_PINS+BANK1_PINS-1:0] gpio_in_i,
   output wire [BANK0_PINS+BANK1_PINS-1:0] gpio_out_o,
   output wire [BANK0_PINS+BANK1_PINS-1:0] gpio_oe_n_o,
   output wire [3*(BANK0_PINS+BANK1_PINS)-1:0] pin_func_o,
   output wire irq_bank0_o,
   output wire irq_bank1_o,
   output wire irq_any_o,
   output wire irq_o
);

   localparam PINS = BANK0_PINS + BANK1_PINS;
   localparam PAD1 = 32 - BANK1_PINS;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   reg [PINS-1:0] out_latch;
   reg [PINS-1:0] next_out_latch;
   reg [BANK0_PINS-1:0] rise_en0;
   reg [BANK1_PINS-1:0] rise_en1;
   reg [BANK0_PINS-1:0] fall_en0;
   reg [BANK1_PINS-1:0] fall_en1;
   reg [BANK0_PINS-1:0] high_en0;
   reg [BANK1_PINS-1:0] high_en1;
   reg [BANK0_PINS-1:0] mask0;
   reg [BANK1_PINS-1:0] mask1;
   reg [31:0] rdata_q;
   reg [31:0] next_rdata;
   wire wr_raise0;
   wire wr_raise1;
   wire wr_lower0;
   wire wr_lower1;
   wire wr_stat0;
   wire wr_stat1;
   wire [PINS-1:0] raise_vec;
   wire [PINS-1:0] lower_vec;
   wire [BANK0_PINS-1:0] clear0;
   wire [BANK1_PINS-1:0] clear1;
   wire [BANK0_PINS-1:0] status0;
   wire [BANK1_PINS-1:0] status1;
   wire fsel_hit;
   wire [31:0] fsel_rdata;
   genvar g;

   // ----------------------------------------------------------------
   // Write strobes
   // ----------------------------------------------------------------
   // Write-only and write-one-to-clear decode
   assign wr_raise0 = wr_i && (addr_i == `GLE_OFF_RAISE0);
   assign wr_raise1 = wr_i && (addr_i == `GLE_OFF_RAISE1);
   assign wr_lower0 = wr_i && (addr_i == `GLE_OFF_LOWER0);
   assign wr_lower1 = wr_i && (addr_i == `GLE_OFF_LOWER1);
   assign wr_stat0 = wr_i && (addr_i == `GLE_OFF_STAT0);
   assign wr_stat1 = wr_i && (addr_i == `GLE_OFF_STAT1);

   // Per-pin raise and lower requests, bank 0 in low bits
   assign raise_vec = {({BANK1_PINS{wr_raise1}} & wdata_i[BANK1_PINS-1:0]),
                       ({BANK0_PINS{wr_raise0}} & wdata_i[BANK0_PINS-1:0])};
   assign lower_vec = {({BANK1_PINS{wr_lower1}} & wdata_i[BANK1_PINS-1:0]),
                       ({BANK0_PINS{wr_lower0}} & wdata_i[BANK0_PINS-1:0])};

   // Status clear pulses, reserved bits dropped
   assign clear0 = {BANK0_PINS{wr_stat0}} & wdata_i[BANK0_PINS-1:0];
   assign clear1 = {BANK1_PINS{wr_stat1}} & wdata_i[BANK1_PINS-1:0];

   // ----------------------------------------------------------------
   // Output latch
   // ----------------------------------------------------------------
   // Latch follows writes whatever the pin direction
   always @* begin
      next_out_latch = out_latch | raise_vec;
      next_out_latch = next_out_latch & ~lower_vec;
   end

   // Latch storage
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         out_latch <= {PINS{1'b0}};
      end else begin
         out_latch <= next_out_latch;
      end
   end

   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------
   // Only output code drives; input and alternate codes release pin
   generate
      for (g = 0; g < PINS; g = g + 1) begin : g_drv
         wire is_out;
         assign is_out = (pin_func_o[3*g+2:3*g] == `GLE_FSEL_OUTPUT);
         assign gpio_oe_n_o[g] = ~is_out;
         assign gpio_out_o[g] = out_latch[g];
      end
   endgenerate

   // ----------------------------------------------------------------
   // Function select
   // ----------------------------------------------------------------
   gle_fsel #(
      .PINS(PINS)
   ) u_fsel (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .addr_i(addr_i),
      .wr_i(wr_i),
      .wdata_i(wdata_i),
      .hit_o(fsel_hit),
      .rdata_o(fsel_rdata),
      .pin_func_o(pin_func_o)
   );

   // ----------------------------------------------------------------
   // Detect enables and interrupt mask
   // ----------------------------------------------------------------
   // Bank 0 enables
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rise_en0 <= {BANK0_PINS{1'b0}};
         fall_en0 <= {BANK0_PINS{1'b0}};
         high_en0 <= {BANK0_PINS{1'b0}};
         mask0 <= {BANK0_PINS{1'b0}};
      end else if (wr_i) begin
         if (addr_i == `GLE_OFF_RISE0) begin
            rise_en0 <= wdata_i[BANK0_PINS-1:0];
         end
         if (addr_i == `GLE_OFF_FALL0) begin
            fall_en0 <= wdata_i[BANK0_PINS-1:0];
         end
         if (addr_i == `GLE_OFF_HIGH0) begin
            high_en0 <= wdata_i[BANK0_PINS-1:0];
         end
         if (addr_i == `GLE_OFF_MASK0) begin
            mask0 <= wdata_i[BANK0_PINS-1:0];
         end
      end
   end

   // Bank 1 enables, reserved bits not stored
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rise_en1 <= {BANK1_PINS{1'b0}};
         fall_en1 <= {BANK1_PINS{1'b0}};
         high_en1 <= {BANK1_PINS{1'b0}};
         mask1 <= {BANK1_PINS{1'b0}};
      end else if (wr_i) begin
         if (addr_i == `GLE_OFF_RISE1) begin
            rise_en1 <= wdata_i[BANK1_PINS-1:0];
         end
         if (addr_i == `GLE_OFF_FALL1) begin
            fall_en1 <= wdata_i[BANK1_PINS-1:0];
         end
         if (addr_i == `GLE_OFF_HIGH1) begin
            high_en1 <= wdata_i[BANK1_PINS-1:0];
         end
         if (addr_i == `GLE_OFF_MASK1) begin
            mask1 <= wdata_i[BANK1_PINS-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Event detection
   // ----------------------------------------------------------------
   gle_event_det #(
      .WIDTH(BANK0_PINS)
   ) u_det0 (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .pin_i(gpio_in_i[BANK0_PINS-1:0]),
      .rise_en_i(rise_en0),
      .fall_en_i(fall_en0),
      .high_en_i(high_en0),
      .clear_i(clear0),
      .status_o(status0)
   );

   gle_event_det #(
      .WIDTH(BANK1_PINS)
   ) u_det1 (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .pin_i(gpio_in_i[PINS-1:BANK0_PINS]),
      .rise_en_i(rise_en1),
      .fall_en_i(fall_en1),
      .high_en_i(high_en1),
      .clear_i(clear1),
      .status_o(status1)
   );

   // ----------------------------------------------------------------
   // Interrupt lines
   // ----------------------------------------------------------------
   // Bank lines and the any-event line ignore the mask
   assign irq_bank0_o = |status0;
   assign irq_bank1_o = |status1;
   assign irq_any_o = irq_bank0_o | irq_bank1_o;
   // Masked summary line
   assign irq_o = (|(status0 & mask0)) | (|(status1 & mask1));

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Read mux; write-only and unmapped words read zero
   always @* begin
      next_rdata = `GLE_RST_WORD;
      case (addr_i)
         `GLE_OFF_STATE0: begin
            next_rdata = gpio_in_i[BANK0_PINS-1:0];
         end
         `GLE_OFF_STATE1: begin
            next_rdata = {{PAD1{1'b0}}, gpio_in_i[PINS-1:BANK0_PINS]};
         end
         `GLE_OFF_STAT0: begin
            next_rdata = status0;
         end
         `GLE_OFF_STAT1: begin
            next_rdata = {{PAD1{1'b0}}, status1};
         end
         `GLE_OFF_RISE0: begin
            next_rdata = rise_en0;
         end
         `GLE_OFF_RISE1: begin
            next_rdata = {{PAD1{1'b0}}, rise_en1};
         end
         `GLE_OFF_FALL0: begin
            next_rdata = fall_en0;
         end
         `GLE_OFF_FALL1: begin
            next_rdata = {{PAD1{1'b0}}, fall_en1};
         end
         `GLE_OFF_HIGH0: begin
            next_rdata = high_en0;
         end
         `GLE_OFF_HIGH1: begin
            next_rdata = {{PAD1{1'b0}}, high_en1};
         end
         `GLE_OFF_MASK0: begin
            next_rdata = mask0;
         end
         `GLE_OFF_MASK1: begin
            next_rdata = {{PAD1{1'b0}}, mask1};
         end
         default: begin
            if (fsel_hit) begin
               next_rdata = fsel_rdata;
            end
         end
      endcase
   end

   // Read data valid only in the cycle after the strobe
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q <= `GLE_RST_WORD;
      end else if (rd_i) begin
         rdata_q <= next_rdata;
      end else begin
         rdata_q <= `GLE_RST_WORD;
      end
   end

   assign rdata_o = rdata_q;

endmodule // gle_top

// [tb/gle_pin_model.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------
// External pads: design drive wins, then test drive, else pull-down
// ----------------------------------------------------------------
module gle_pin_model #(
   parameter PINS = 54
) (
   input wire [PINS-1:0] out_i,
   input wire [PINS-1:0] oe_n_i,
   input wire [PINS-1:0] ext_i,
   input wire [PINS-1:0] ext_oe_n_i,
   output wire [PINS-1:0] pin_o
);
   // Resolved level, pads rest low when nobody drives
   assign pin_o = (~oe_n_i & out_i) | (oe_n_i & ~ext_oe_n_i & ext_i);
endmodule // gle_pin_model

// [tb/gle_top_asserts.sv]
`timescale 1ns/10ps
module gle_chk #(
   parameter BANK0_PINS = 32,
   parameter BANK1_PINS = 22
) (
   input wire sys_clk_i,
   input wire rst_n_i,
   input wire [7:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [31:0] rdata_o,
   input wire [BANK0_PINS+BANK1_PINS-1:0] gpio_in_i,
   input wire [BANK0_PINS+BANK1_PINS-1:0] gpio_out_o,
   input wire [BANK0_PINS+BANK1_PINS-1:0] gpio_oe_n_o,
   input wire irq_bank0_o,
   input wire irq_bank1_o,
   input wire irq_any_o
);
   reg [BANK0_PINS-1:0] h0, h1, h2, ren, fen, hen;
   wire [BANK0_PINS-1:0] hit;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   // Bank 0 events due at the next edge
   assign hit = (ren & ~h2 & h1 & h0) | (fen & h2 & ~h1 & ~h0) | (hen & h0);
   // Sample history and enable shadows
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         h0 <= {BANK0_PINS{1'b0}};
         h1 <= {BANK0_PINS{1'b0}};
         h2 <= {BANK0_PINS{1'b0}};
         ren <= {BANK0_PINS{1'b0}};
         fen <= {BANK0_PINS{1'b0}};
         hen <= {BANK0_PINS{1'b0}};
      end else begin
         h0 <= gpio_in_i[BANK0_PINS-1:0];
         h1 <= h0;
         h2 <= h1;
         if (wr_i && addr_i == 8'h48) ren <= wdata_i[BANK0_PINS-1:0];
         if (wr_i && addr_i == 8'h50) fen <= wdata_i[BANK0_PINS-1:0];
         if (wr_i && addr_i == 8'h58) hen <= wdata_i[BANK0_PINS-1:0];
      end
   end
   sequence s_wr(logic [7:0] a);
      wr_i && addr_i == a;
   endsequence
   sequence s_rd(logic [7:0] a);
      rd_i && addr_i == a;
   endsequence
   AST_RAISE_ONES: assert property (s_wr(8'h20) |=>
      (gpio_out_o[31:0] & $past(wdata_i)) == $past(wdata_i))
      else $error("raise write missed a bit");
   AST_RAISE_ZEROS: assert property (s_wr(8'h20) |=>
      (gpio_out_o[31:0] & ~$past(wdata_i)) ==
      ($past(gpio_out_o[31:0]) & ~$past(wdata_i)))
      else $error("raise write touched a zero bit");
   AST_LOWER: assert property (s_wr(8'h28) |=>
      (gpio_out_o[31:0] & $past(wdata_i)) == 32'h0)
      else $error("lower write missed a bit");
   AST_DIR_KEEP: assert property ((s_wr(8'h20) or s_wr(8'h28)) |=>
      $stable(gpio_oe_n_o)) else $error("latch write changed direction");
   AST_STATE0: assert property (s_rd(8'h30) |=>
      rdata_o == $past(gpio_in_i[31:0])) else $error("bank0 level wrong");
   AST_STATE1: assert property (s_rd(8'h34) |=>
      rdata_o[BANK1_PINS-1:0] ==
      $past(gpio_in_i[BANK0_PINS+BANK1_PINS-1:BANK0_PINS]))
      else $error("bank1 level wrong");
   AST_EVENT_SET: assert property (|hit |=> irq_bank0_o)
      else $error("enabled event not flagged");
   AST_NO_SPUR: assert property (!irq_bank0_o && !(|hit) |=>
      !irq_bank0_o) else $error("status set without event");
   AST_CLEAR: assert property (wr_i && addr_i == 8'h40
      && wdata_i == 32'hffff_ffff && !(|hit) |=> !irq_bank0_o)
      else $error("status not cleared");
   AST_ANY: assert property (irq_any_o == (irq_bank0_o | irq_bank1_o))
      else $error("any-event line wrong");
   AST_RESV: assert property (s_rd(8'h4c) |=> rdata_o[31:22] == 10'h0)
      else $error("reserved bits not zero");
endmodule // gle_chk

bind gle_top gle_chk #(.BANK0_PINS(BANK0_PINS), .BANK1_PINS(BANK1_PINS))
   u_chk (.sys_clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
   .gpio_in_i, .gpio_out_o, .gpio_oe_n_o, .irq_bank0_o, .irq_bank1_o,
   .irq_any_o);

// [tb/tb.sv]
`timescale 1ns/10ps
module tb;
   reg sys_clk = 1'b0;
   reg rst_n = 1'b0;
   reg [7:0] addr = 8'h00;
   reg [31:0] wdata = 32'h0;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg [53:0] ext = 54'h0;
   reg [53:0] ext_oe_n = {54{1'b1}};
   wire [31:0] rdata;
   wire [53:0] pin, gout, goe_n;
   wire irq0, irq1, irqa, irq;
   wire [161:0] pfunc;
   integer n_fail = 0;
   integer cmp_count = 0;
   integer i;
   reg [31:0] rv;
   // Rows: address, write data, read-back value
   reg [71:0] rows [0:9] = '{72'h48_a5a5a5a5_a5a5a5a5,
      72'h4c_ffffffff_003fffff, 72'h50_0f0f0f0f_0f0f0f0f,
      72'h54_ffffffff_003fffff, 72'h58_12345678_12345678,
      72'h5c_ffffffff_003fffff, 72'h60_ffffffff_ffffffff,
      72'h64_ffffffff_003fffff, 72'h20_ffffffff_00000000,
      72'h84_ffffffff_00000000};

   always #10 sys_clk = ~sys_clk;

   gle_pin_model u_pads (.out_i(gout), .oe_n_i(goe_n), .ext_i(ext),
      .ext_oe_n_i(ext_oe_n), .pin_o(pin));
   gle_top u_dut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .gpio_in_i(pin), .gpio_out_o(gout), .gpio_oe_n_o(goe_n),
      .pin_func_o(pfunc), .irq_bank0_o(irq0), .irq_bank1_o(irq1),
      .irq_any_o(irqa), .irq_o(irq));

   // ----------------------------------------------------------------
   // Bus, pad and compare helpers
   // ----------------------------------------------------------------
   task automatic wr_reg(input [7:0] a, input [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rd_reg(input [7:0] a, output [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic drive(input integer p, input v);
      @(posedge sys_clk);
      ext[p] <= v;
      ext_oe_n[p] <= 1'b0;
      repeat (5) @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(input [63:0] seen, input [63:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         n_fail = n_fail + 1;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Watchdog against a hung handshake
   initial begin
      #100000;
      n_fail = n_fail + 1;
      report_and_stop;
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      // Reset value, write, read-back, restore
      for (i = 0; i < 10; i = i + 1) begin
         rd_reg(rows[i][71:64], rv);
         chk(rv, 32'h0);
         wr_reg(rows[i][71:64], rows[i][63:32]);
         rd_reg(rows[i][71:64], rv);
         chk(rv, rows[i][31:0]);
         wr_reg(rows[i][71:64], 32'h0);
      end
      wr_reg(8'h28, 32'hffff_ffff);
      // Rising edge, pin 3, unmasked
      wr_reg(8'h48, 32'h8);
      wr_reg(8'h60, 32'h8);
      drive(3, 1'b1);
      chk({irq0, irqa, irq}, 3'b111);
      rd_reg(8'h40, rv);
      chk(rv, 32'h8);
      wr_reg(8'h40, 32'hffff_ffff);
      rd_reg(8'h40, rv);
      chk({rv, irq0}, 33'h0);
      // Fall not enabled, then one-sample glitch
      drive(3, 1'b0);
      @(posedge sys_clk);
      ext[3] <= 1'b1;
      drive(3, 1'b0);
      rd_reg(8'h40, rv);
      chk(rv, 32'h0);
      // Both edges on pin 4
      wr_reg(8'h48, 32'h10);
      wr_reg(8'h50, 32'h10);
      drive(4, 1'b1);
      rd_reg(8'h40, rv);
      chk(rv, 32'h10);
      wr_reg(8'h40, 32'h10);
      drive(4, 1'b0);
      rd_reg(8'h40, rv);
      chk(rv, 32'h10);
      wr_reg(8'h40, 32'h10);
      // Falling edge on pin 37, bank 1
      wr_reg(8'h54, 32'h20);
      drive(37, 1'b1);
      rd_reg(8'h44, rv);
      chk(rv, 32'h0);
      drive(37, 1'b0);
      chk({irq1, irq0, irqa}, 3'b101);
      rd_reg(8'h44, rv);
      chk(rv, 32'h20);
      wr_reg(8'h44, 32'h20);
      // High level on pin 6, masked off
      wr_reg(8'h58, 32'h40);
      drive(6, 1'b1);
      rd_reg(8'h40, rv);
      chk(rv, 32'h40);
      wr_reg(8'h40, 32'h40);
      rd_reg(8'h40, rv);
      chk({rv, irq0, irq}, {32'h40, 2'b10});
      drive(6, 1'b0);
      wr_reg(8'h40, 32'h40);
      rd_reg(8'h40, rv);
      chk(rv, 32'h0);
      // Output latch and direction
      wr_reg(8'h00, 32'h1);
      chk(goe_n[1:0], 2'b10);
      wr_reg(8'h20, 32'h3);
      chk(gout[1:0], 2'b11);
      rd_reg(8'h30, rv);
      chk(rv, 32'h1);
      wr_reg(8'h28, 32'h1);
      chk(gout[1:0], 2'b10);
      wr_reg(8'h00, 32'h9);
      chk(pfunc[5:0], 6'h09);
      rd_reg(8'h30, rv);
      chk(rv, 32'h2);
      wr_reg(8'h24, 32'h0020_0000);
      rd_reg(8'h34, rv);
      chk({gout[53], rv}, 33'h1_0000_0000);
      // Reset in mid-run
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 chk({gout[53], gout[1], goe_n[1:0]}, 4'b0011);
      rst_n <= 1'b1;
      rd_reg(8'h00, rv);
      chk(rv, 32'h0);
      report_and_stop;
   end
endmodule // tb
